//--- pkg/nand_host_pkg.sv
package nand_host_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_COL_SETUP = 8'h05;
  localparam logic [7:0] CMD_COL_CONFIRM = 8'he0;
  // Own registers, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COL = 8'h04;
  localparam logic [7:0] OFS_ROW = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  // Control fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_RANDOM_BIT = 1;
  localparam int CTRL_WIDE_BIT = 2;
  localparam int CTRL_WP_BIT = 3;
  localparam int CTRL_GUARD_BIT = 4;
  localparam int CTRL_EXT_OUT_BIT = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Address geometry
  localparam int ADDR_CYCLES = 5;
  localparam int COL_CYCLES = 2;
  localparam int PAGE_BYTES = 2160;
  localparam int PAGE_WORDS = 1080;
  // Timing: strobe phases in ns, counted at 100 MHz
  localparam int CLK_NS = 10;
  localparam int STROBE_NS = 30;
  localparam int FAST_CYCLE_NS = 20;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] FAST_CYC =
    4'((FAST_CYCLE_NS / 2 + CLK_NS - 1) / CLK_NS);

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_low;
    logic [15:0] dout;
    logic doe;
  } nand_pins_t;
endpackage : nand_host_pkg

//--- rtl/nand_host_ctrl.sv
// Behaviour
// - Commands, addresses and data share eight or sixteen data lines.
// - Host holds write protect low through power-up and power-down.
// - Five address cycles: two column, then three row.
// - Byte-wide column A0-A11 in cycles one and two, upper nibble low.
// - Byte-wide plane bit A18; A29 only at 4Gb; unused bits low.
// - Word-wide column A0-A10, row A11-A28, upper lines low.
// - Read is 00h, address cycles, 30h, busy, then streamed data.
// - Host reads no data before ready/busy shows ready.
// - Fast read cycles sample data at the next strobe fall.
// - Column jump is 05h, two column cycles, E0h.
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl (
  input wire logic clock, // 100 MHz
  input wire logic resetn, // Async, active low
  input wire logic hsel, // AHB-Lite select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write access
  input wire logic [2:0] hsize, // Word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  output var nand_host_pkg::nand_pins_t pins, // Flash strobes and data out
  input wire logic [15:0] data_in, // Shared data lines in
  input wire logic ready_busy_n, // Pulled-up ready/busy
  output logic write_protect_n, // Write protect pin
  output logic whole_chip_guard // Protection pin
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_CMD1 = 4'b0001, S_ADDR = 4'b0010,
    S_CMD2 = 4'b0011, S_WAIT = 4'b0100, S_READ = 4'b0101,
    S_DONE = 4'b0110, S_WE_HI = 4'b0111, S_STALL = 4'b1000
  } state_t;

  state_t state_r, ret_r;
  logic [31:0] ctrl_r, col_r, row_r, count_r, data_r;
  logic [2:0] acyc_r;
  logic [3:0] tmr_r;
  logic [11:0] left_r;
  logic wr_ph_r, rd_full_r, busy_seen_r, err_r;
  logic [7:0] addr_ph_r;
  logic wr_ph_nxt;
  logic wide;
  logic [7:0] acyc_byte;

  // Address layout: byte-wide column takes 12 bits, word-wide 11; row bytes the same for both widths
  function automatic logic [7:0] addr_byte(input logic [2:0] n,
      input logic [31:0] col, input logic [31:0] row, input logic w);
    case (n)
      3'd0: addr_byte = col[7:0];
      3'd1: addr_byte = w ? {5'h00, col[10:8]} : {4'h0, col[11:8]};
      3'd2: addr_byte = row[7:0];
      3'd3: addr_byte = row[15:8];
      3'd4: addr_byte = {6'h00, row[17:16]};
      default: addr_byte = 8'h00;
    endcase
  endfunction : addr_byte

  assign wide = ctrl_r[nand_host_pkg::CTRL_WIDE_BIT];
  assign acyc_byte = addr_byte(acyc_r, col_r, row_r, wide);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign write_protect_n = ctrl_r[nand_host_pkg::CTRL_WP_BIT];
  assign whole_chip_guard = ctrl_r[nand_host_pkg::CTRL_GUARD_BIT];

  // AHB-Lite address phase capture
  assign wr_ph_nxt = hsel & hready & htrans[1];
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ph_r <= 1'b0;
      addr_ph_r <= 8'h00;
    end else if (hready) begin
      wr_ph_r <= wr_ph_nxt & hwrite;
      addr_ph_r <= haddr[7:0];
    end
  end

  logic rd_go, go_w;
  logic rd_ph_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) rd_ph_r <= 1'b0;
    else if (hready) rd_ph_r <= wr_ph_nxt & ~hwrite;
  end
  assign rd_go = rd_ph_r && addr_ph_r == nand_host_pkg::OFS_DATA;
  assign go_w = wr_ph_r && addr_ph_r == nand_host_pkg::OFS_CTRL &&
                hwdata[nand_host_pkg::CTRL_GO_BIT] && state_r == S_IDLE;

  // Register writes; GO self-clears, WP resets low for power-up safety
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= nand_host_pkg::CTRL_RESET;
      col_r <= 32'h0000_0000;
      row_r <= 32'h0000_0000;
      count_r <= 32'h0000_0000;
    end else if (wr_ph_r) begin
      case (addr_ph_r)
        nand_host_pkg::OFS_CTRL: ctrl_r <= hwdata & 32'h0000_003e;
        nand_host_pkg::OFS_COL: col_r <= hwdata;
        nand_host_pkg::OFS_ROW: row_r <= hwdata;
        nand_host_pkg::OFS_COUNT: count_r <= hwdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (addr_ph_r)
      nand_host_pkg::OFS_CTRL: hrdata = ctrl_r;
      nand_host_pkg::OFS_COL: hrdata = col_r;
      nand_host_pkg::OFS_ROW: hrdata = row_r;
      nand_host_pkg::OFS_COUNT: hrdata = count_r;
      nand_host_pkg::OFS_STATUS:
        hrdata = {26'h0, err_r, busy_seen_r, rd_full_r, ready_busy_n,
                  left_r != 12'h000, state_r != S_IDLE};
      nand_host_pkg::OFS_DATA: hrdata = data_r;
      default: hrdata = 32'h0000_0000;
    endcase
  end

  // Sequencer: every strobe phase lasts at least STROBE_CYC cycles, except fast read phases at FAST_CYC
  logic tmr_done;
  logic extended_data_out;
  assign tmr_done = tmr_r == 4'h0;
  assign extended_data_out = ctrl_r[nand_host_pkg::CTRL_EXT_OUT_BIT];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      ret_r <= S_IDLE;
      tmr_r <= 4'h0;
      acyc_r <= 3'd0;
      left_r <= 12'h000;
      pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                read_strobe_low: 1'b1, dout: 16'h0000, doe: 1'b0};
      data_r <= 32'h0000_0000;
      rd_full_r <= 1'b0;
      busy_seen_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (!tmr_done) tmr_r <= tmr_r - 4'h1;
      if (rd_go) rd_full_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          pins.ce_n <= 1'b1;
          if (go_w) begin
            err_r <= ready_busy_n == 1'b0;
            pins.ce_n <= 1'b0;
            pins.cle <= 1'b1;
            pins.ale <= 1'b0;
            pins.we_n <= 1'b0;
            pins.doe <= 1'b1;
            pins.dout <= hwdata[nand_host_pkg::CTRL_RANDOM_BIT] ?
              {8'h00, nand_host_pkg::CMD_COL_SETUP} :
              {8'h00, nand_host_pkg::CMD_READ_SETUP};
            acyc_r <= hwdata[nand_host_pkg::CTRL_RANDOM_BIT] ? 3'd0 : 3'd0;
            left_r <= count_r[11:0];
            ret_r <= S_ADDR;
            tmr_r <= nand_host_pkg::STROBE_CYC;
            state_r <= S_WE_HI;
          end
        end
        S_WE_HI: if (tmr_done) begin
          pins.we_n <= 1'b1; // rising edge latches
          tmr_r <= nand_host_pkg::STROBE_CYC;
          state_r <= S_STALL;
        end
        S_STALL: if (tmr_done) begin
          pins.cle <= 1'b0;
          pins.ale <= 1'b0;
          state_r <= ret_r;
        end
        S_ADDR: begin
          pins.ale <= 1'b1;
          pins.we_n <= 1'b0;
          pins.dout <= {8'h00, acyc_byte};
          acyc_r <= acyc_r + 3'd1;
          tmr_r <= nand_host_pkg::STROBE_CYC;
          // column only for a jump, five cycles for a read
          if (ctrl_r[nand_host_pkg::CTRL_RANDOM_BIT] ?
              acyc_r == 3'(nand_host_pkg::COL_CYCLES - 1) :
              acyc_r == 3'(nand_host_pkg::ADDR_CYCLES - 1))
            ret_r <= S_CMD2;
          else
            ret_r <= S_ADDR;
          state_r <= S_WE_HI;
        end
        S_CMD2: begin
          pins.cle <= 1'b1;
          pins.we_n <= 1'b0;
          pins.dout <= ctrl_r[nand_host_pkg::CTRL_RANDOM_BIT] ?
            {8'h00, nand_host_pkg::CMD_COL_CONFIRM} :
            {8'h00, nand_host_pkg::CMD_READ_CONFIRM};
          tmr_r <= nand_host_pkg::STROBE_CYC;
          ret_r <= S_WAIT;
          busy_seen_r <= 1'b0;
          state_r <= S_WE_HI;
        end
        S_WAIT: begin
          pins.doe <= 1'b0;
          if (!ready_busy_n) busy_seen_r <= 1'b1;
          // stream only once ready; chip select kept low throughout
          if (ready_busy_n && tmr_done) begin
            state_r <= left_r == 12'h000 ? S_DONE : S_READ;
            tmr_r <= nand_host_pkg::STROBE_CYC;
          end
        end
        S_READ: if (!rd_full_r || rd_go) begin
          if (tmr_done && pins.read_strobe_low) begin
            // in fast mode sample before the next fall
            if (extended_data_out) begin
              data_r <= {16'h0000, wide ? data_in : {8'h00, data_in[7:0]}};
              rd_full_r <= left_r != count_r[11:0];
            end
            pins.read_strobe_low <= 1'b0;
            tmr_r <= extended_data_out ? nand_host_pkg::FAST_CYC :
              nand_host_pkg::STROBE_CYC;
          end else if (tmr_done) begin
            if (!extended_data_out) begin
              data_r <= {16'h0000, wide ? data_in : {8'h00, data_in[7:0]}};
              rd_full_r <= 1'b1;
            end
            pins.read_strobe_low <= 1'b1;
            left_r <= left_r - 12'h001;
            tmr_r <= extended_data_out ? nand_host_pkg::FAST_CYC :
              nand_host_pkg::STROBE_CYC;
            if (left_r == 12'h001) state_r <= S_DONE;
          end
        end
        S_DONE: begin
          // Fast mode: last word still on the lines after the final rise
          if (extended_data_out && !rd_full_r && tmr_done) begin
            data_r <= {16'h0000, wide ? data_in : {8'h00, data_in[7:0]}};
            rd_full_r <= count_r[11:0] != 12'h000;
          end
          if (tmr_done && (!extended_data_out || !rd_full_r || rd_go))
            state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  property p_no_both_strobes;
    @(posedge clock) disable iff (!resetn)
      !(pins.cle && pins.ale);
  endproperty
  a_no_both_strobes: assert property (p_no_both_strobes)
    else $error("command and address strobes both high");

  property p_latch_stable;
    @(posedge clock) disable iff (!resetn)
      $rose(pins.we_n) |-> $stable(pins.dout) && pins.doe;
  endproperty
  a_latch_stable: assert property (p_latch_stable)
    else $error("data moved at write strobe rise");

  property p_no_read_busy;
    @(posedge clock) disable iff (!resetn)
      (state_r == S_WAIT && !ready_busy_n) |=> pins.read_strobe_low;
  endproperty
  a_no_read_busy: assert property (p_no_read_busy)
    else $error("read strobe while busy");

  property p_ce_held;
    @(posedge clock) disable iff (!resetn)
      state_r == S_WAIT |-> !pins.ce_n;
  endproperty
  a_ce_held: assert property (p_ce_held)
    else $error("chip select raised during latency");

  property p_idle_deselect;
    @(posedge clock) disable iff (!resetn)
      (state_r == S_IDLE && !go_w) |=> pins.ce_n;
  endproperty
  a_idle_deselect: assert property (p_idle_deselect)
    else $error("idle without deselect");

  property p_addr_high_low;
    @(posedge clock) disable iff (!resetn)
      pins.ale |-> pins.dout[15:8] == 8'h00;
  endproperty
  a_addr_high_low: assert property (p_addr_high_low)
    else $error("upper lines set in address cycle");

  sequence s_we_low;
    !pins.we_n ##1 !pins.we_n ##1 !pins.we_n;
  endsequence
  property p_we_width;
    @(posedge clock) disable iff (!resetn)
      $fell(pins.we_n) |-> s_we_low;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe low too short");

  property p_fifth_cycle;
    @(posedge clock) disable iff (!resetn)
      (state_r == S_ADDR && acyc_r == 3'd4) |=> pins.dout[7:2] == 6'h00;
  endproperty
  a_fifth_cycle: assert property (p_fifth_cycle)
    else $error("fifth address cycle upper bits set");

  property p_no_drive_on_read;
    @(posedge clock) disable iff (!resetn)
      !pins.read_strobe_low |-> !pins.doe;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read)
    else $error("host drives data lines during a read strobe");

  property p_read_when_ready;
    @(posedge clock) disable iff (!resetn)
      $fell(pins.read_strobe_low) |-> ready_busy_n;
  endproperty
  a_read_when_ready: assert property (p_read_when_ready)
    else $error("read strobe fell while busy");

  property p_jump_col_only;
    @(posedge clock) disable iff (!resetn)
      (state_r == S_ADDR && ctrl_r[nand_host_pkg::CTRL_RANDOM_BIT]) |->
        acyc_r < 3'(nand_host_pkg::COL_CYCLES);
  endproperty
  a_jump_col_only: assert property (p_jump_col_only)
    else $error("row cycle sent during a column jump");

  // Confirm command only after the full set of address cycles
  property p_addr_count;
    @(posedge clock) disable iff (!resetn)
      state_r == S_CMD2 |->
        acyc_r == (ctrl_r[nand_host_pkg::CTRL_RANDOM_BIT] ?
                   3'(nand_host_pkg::COL_CYCLES) :
                   3'(nand_host_pkg::ADDR_CYCLES));
  endproperty
  a_addr_count: assert property (p_addr_count)
    else $error("wrong number of address cycles before confirm");
endmodule : nand_host_ctrl
`default_nettype wire

//--- sim/nand_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
  parameter int busy_ns = 400,
  parameter int read_access_delay = 8
) (
  input wire nand_host_pkg::nand_pins_t pins, // Host strobes and data
  input wire logic wide, // Word-wide variant
  output logic [15:0] data_out, // Shared data lines out
  output logic busy_n, // Open drain, 1 when released
  output logic [4:0][15:0] addr_b, // Address cycles seen
  output logic [3:0] n_addr, // Address cycle count
  output logic bad // Protocol fault seen
);
  logic [7:0] c;
  logic [17:0] row_r;
  logic [11:0] col_r;
  function automatic logic [15:0] mk(logic [17:0] r, logic [11:0] k);
    mk = {k[7:0] ^ r[15:8], k[7:0] + r[7:0]};
    if (!wide) mk[15:8] = 8'h00;
  endfunction : mk
  initial begin
    data_out = 16'h0000;
    busy_n = 1'b1;
    n_addr = 4'h0;
    bad = 1'b0;
    c = 8'hff;
    row_r = 18'h00000;
    col_r = 12'h000;
  end
  // No program or erase path exists, so protection always holds
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle && pins.ale) begin
      bad = 1'b1;
    end else if (!pins.ce_n && pins.cle) begin
      if (pins.dout[7:0] == 8'h30 && (c != 8'h00 || n_addr != 4'h5)) bad = 1'b1;
      if (pins.dout[7:0] == 8'he0 && (c != 8'h05 || n_addr != 4'h2)) bad = 1'b1;
      c = pins.dout[7:0];
      if (c == 8'h00 || c == 8'h05) n_addr = 4'h0;
      if (c == 8'h30) begin
        row_r = {addr_b[4][1:0], addr_b[3][7:0], addr_b[2][7:0]};
        // Chip select is ignored while busy, so nothing cuts this short
        busy_n = 1'b0;
        busy_n <= #(busy_ns) 1'b1;
      end
      if (c == 8'h30 || c == 8'he0) begin
        col_r = {~wide & addr_b[1][3], addr_b[1][2:0], addr_b[0][7:0]};
      end
    end else if (!pins.ce_n && pins.ale) begin
      if (n_addr > 4'h4) bad = 1'b1;
      else addr_b[n_addr] = pins.dout;
      n_addr = n_addr + 4'h1;
    end
  end
  // Word held until the next fall, which lets fast hosts sample late
  always @(negedge pins.read_strobe_low) begin
    if (!pins.ce_n) begin
      if (!busy_n) bad = 1'b1;
      if (col_r >= (wide ? 12'h438 : 12'h870)) bad = 1'b1;
      data_out = ~data_out;
      data_out <= #(read_access_delay) mk(row_r, col_r);
      col_r = col_r + 12'h001;
    end
  end
  always @(posedge pins.ce_n) data_out = ~data_out;
endmodule : nand_dev_model
`default_nettype wire

//--- sim/tb_nand_bus_cmd_addr_page_read.sv
`timescale 1ns/1ps
`default_nettype none
module tb_nand_bus_cmd_addr_page_read;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic wide = 1'b0;
  logic ck = 1'b0;
  logic hreadyout, hresp, write_protect_n, whole_chip_guard, busy_n, bad;
  logic [31:0] hrdata;
  logic [15:0] data_in;
  logic [4:0][15:0] addr_b;
  logic [3:0] n_addr;
  nand_host_pkg::nand_pins_t pins;
  wire logic ready_busy_n = busy_n; // Pull-up: the model only sinks
  int n_mismatch = 0, checked = 0, cyc = 0, seed = 16944;
  logic [31:0] exp_q[$];
  nand_host_ctrl dut_u (.clock(clock), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pins(pins), .data_in(data_in),
    .ready_busy_n(ready_busy_n), .write_protect_n(write_protect_n),
    .whole_chip_guard(whole_chip_guard));
  nand_dev_model dev_u (.pins(pins), .wide(wide), .data_out(data_in),
    .busy_n(busy_n), .addr_b(addr_b), .n_addr(n_addr), .bad(bad));
  initial forever #5 clock = ~clock;
  function automatic logic [15:0] word_of(logic [17:0] r, logic [11:0] k);
    word_of = {k[7:0] ^ r[15:8], k[7:0] + r[7:0]};
    if (!wide) word_of[15:8] = 8'h00;
  endfunction : word_of
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] e,
                     input string m);
    checked++;
    if (got !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      wrap_up();
    end
    if (ck && hreadyout === 1'b1)
      chk(hrdata, exp_q.pop_front(), "read data");
  end
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic c, input logic [31:0] e, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    if (c) exp_q.push_back(e);
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ck <= c;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0, "bus response");
    ck <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, 1'b0, 32'h0, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, 1'b1, e, q);
  endtask : rd
  // Polls status without a note; only the final bit value is judged
  task automatic wait_bit(input int b, input logic v);
    logic [31:0] q;
    int t;
    t = 0;
    do begin
      bus(nand_host_pkg::OFS_STATUS, 1'b0, 32'h0, 1'b0, 32'h0, q);
      t++;
    end while (q[b] !== v && t < 3000);
    chk({31'h0, q[b]}, {31'h0, v}, "status wait");
  endtask : wait_bit
  task automatic read_words(input logic [17:0] r, input logic [11:0] k,
                            input int n);
    for (int i = 0; i < n; i++) begin
      wait_bit(3, 1'b1);
      rd(nand_host_pkg::OFS_DATA, {16'h0, word_of(r, k + 12'(i))});
    end
    wait_bit(0, 1'b0);
  endtask : read_words
  initial begin
    logic [31:0] ctrl;
    logic [17:0] row;
    logic [11:0] col;
    logic [39:0] ea;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk({31'h0, write_protect_n}, 32'h0, "protect at power-up");
    chk({31'h0, pins.ce_n}, 32'h1, "idle chip select");
    rd(nand_host_pkg::OFS_CTRL, nand_host_pkg::CTRL_RESET);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wide <= m[0];
      row = 18'($random(seed));
      col = 12'($random(seed)) & (m[0] ? 12'h3ff : 12'h7ff);
      ctrl = {26'h0, m[1], m[1] ^ m[0], 1'b1, m[0], 2'b00};
      wr(nand_host_pkg::OFS_ROW, {14'h0, row});
      wr(nand_host_pkg::OFS_COL, {20'h0, col});
      wr(nand_host_pkg::OFS_COUNT, 32'(m + 3));
      wr(nand_host_pkg::OFS_CTRL, ctrl | 32'h1);
      read_words(row, col, m + 3);
      wait_bit(4, 1'b1);
      ea = {6'h0, row[17:16], row[15:8], row[7:0], 4'h0,
            col[11:8] & (m[0] ? 4'h7 : 4'hf), col[7:0]};
      for (int k = 0; k < 5; k++) begin
        chk({16'h0, addr_b[k]}, {24'h0, ea[k*8 +: 8]}, "address cycle");
      end
      rd(nand_host_pkg::OFS_CTRL, ctrl);
      chk({30'h0, whole_chip_guard, write_protect_n}, {30'h0, ctrl[4], 1'b1},
          "protect pins");
      col = col ^ 12'h055;
      wr(nand_host_pkg::OFS_COL, {20'h0, col});
      wr(nand_host_pkg::OFS_COUNT, 32'h2);
      wr(nand_host_pkg::OFS_CTRL, ctrl | 32'h3);
      read_words(row, col, 2);
      chk({28'h0, n_addr}, 32'h2, "jump address cycles");
    end
    chk({31'h0, bad}, 32'h0, "device protocol");
    wrap_up();
  end
endmodule : tb_nand_bus_cmd_addr_page_read
`default_nettype wire
